// ### verilog/bus_fabric_pkg.sv
// shared constants of the core-side bus fabric: bus widths, access size codes,
// peripheral window placement and the fixed read latency.
// assumes one clock domain; every user writes bus_fabric_pkg::name.
package bus_fabric_pkg;

    // bus widths
    localparam int PROG_AW   = 21;          // program address width
    localparam int DATA_AW   = 24;          // primary and secondary address width
    localparam int WORD_W    = 16;          // program, secondary and peripheral data
    localparam int LONG_W    = 32;          // primary read and write data
    localparam int PERIPH_AW = 16;          // word offset inside the peripheral window

    // access size codes on the primary port; code 3 is treated as a word
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // default memory depths, as address widths in words
    localparam int DMEM_AW_DEF = 12;        // 4096 words of data memory
    localparam int PMEM_AW_DEF = 14;        // 16384 words of program memory

    // peripheral window, in word addresses, above the data memory
    localparam logic [23:0] IO_BASE_DEF  = 24'h00F000;
    localparam logic [23:0] IO_WORDS_DEF = 24'h001000;

    // edges from the taking edge of a read to its registered answer
    localparam int READ_LATENCY = 2;

    // byte lane that a byte address with bit 0 clear selects
    localparam logic LANE_LOW = 1'b0;

endpackage : bus_fabric_pkg

// ### verilog/core_bus_fabric.sv
// core-side bus fabric: program memory port, 32-bit primary data port with
// byte/word/long sizes, word-only secondary read port and the peripheral bus.
// assumes the core drives all request inputs synchronous to mclk and that the
// peripherals answer a read in the same cycle that the read strobe is high.
module core_bus_fabric #(
    parameter int          DMEM_AW  = bus_fabric_pkg::DMEM_AW_DEF,
    parameter int          PMEM_AW  = bus_fabric_pkg::PMEM_AW_DEF,
    parameter logic [23:0] IO_BASE  = bus_fabric_pkg::IO_BASE_DEF,
    parameter logic [23:0] IO_WORDS = bus_fabric_pkg::IO_WORDS_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    // program memory port
    input  wire logic [20:0] prog_addr,
    input  wire logic        prog_rd,
    input  wire logic        prog_wr,
    output logic      [15:0] prog_rdata,
    output logic             prog_rvalid,
    // primary data port
    input  wire logic [23:0] primary_data_addr,
    input  wire logic        pri_rd,
    input  wire logic        pri_wr,
    input  wire logic [1:0]  pri_size,
    input  wire logic [31:0] core_wdata,
    output logic      [31:0] core_rdata,
    output logic             core_rvalid,
    // secondary read port
    input  wire logic [23:0] secondary_data_addr,
    input  wire logic        sec_rd,
    output logic      [15:0] secondary_read_data,
    output logic             sec_rvalid,
    // peripheral register bus
    output logic      [15:0] periph_addr,
    output logic      [15:0] periph_wdata,
    output logic             periph_rd,
    output logic             periph_wr,
    input  wire logic [15:0] periph_rdata
);

    // one past the last word of the peripheral window; the window is meant to sit
    // above the data memory, so a word address can never decode to both at once
    // and a write is never split between a memory word and a peripheral register
    localparam logic [23:0] IO_END = IO_BASE + IO_WORDS;

    // memories, word organised
    // neither array is cleared by reset: a word read before its first write is
    // unknown, so the core must load what it reads
    logic [15:0] dmem [2**DMEM_AW];
    logic [15:0] pmem [2**PMEM_AW];

    // stage 1 request state
    // everything a read needs at its answer edge is kept here, so the request
    // inputs may change in the very next cycle
    logic               pri_rd_r;
    logic               pri_io_r;
    logic               pri_dm_r;
    logic [1:0]         pri_size_r;
    logic               pri_lane_r;
    logic [DMEM_AW-1:0] pri_idx_r;
    logic               sec_rd_r;
    logic               sec_dm_r;
    logic [DMEM_AW-1:0] sec_idx_r;
    logic               prog_rd_r;
    logic               prog_pm_r;
    logic [PMEM_AW-1:0] prog_idx_r;

    // peripheral bus registers
    // the bus is registered so every strobe is a clean one-cycle pulse
    logic [15:0] periph_addr_r;
    logic [15:0] periph_wdata_r;
    logic        periph_rd_r;
    logic        periph_wr_r;

    // answer registers
    // each data register holds its last answer; the valid flags mark the one
    // cycle in which the data is new
    logic [31:0] core_rdata_r;
    logic [31:0] core_rdata_nxt;
    logic        core_rvalid_r;
    logic [15:0] sec_data_r;
    logic [15:0] sec_data_nxt;
    logic        sec_rvalid_r;
    logic [15:0] prog_rdata_r;
    logic [15:0] prog_rdata_nxt;
    logic        prog_rvalid_r;

    // primary address decode by size
    // a word or long address counts words, a byte address counts bytes; the byte
    // address has its top bit cleared first and then drops bit 0 to find its word
    // a long always starts on an even word, whatever bit 0 of the address says
    // byte accesses are kept out of the peripheral window on purpose
    wire        is_byte  = (pri_size == bus_fabric_pkg::SZ_BYTE);
    wire        is_long  = (pri_size == bus_fabric_pkg::SZ_LONG);
    wire [23:0] eff_addr = is_byte ? {1'b0, primary_data_addr[22:0]}
                                   : primary_data_addr;
    wire [23:0] pri_widx = is_byte ? {1'b0, eff_addr[23:1]} :
                           is_long ? {eff_addr[23:1], 1'b0} : eff_addr;
    wire        pri_lane = eff_addr[0];
    wire        pri_io   = !is_byte && (pri_widx >= IO_BASE)
                                    && (pri_widx < IO_END);
    wire        pri_dm   = (pri_widx[23:DMEM_AW] == '0);
    wire [23:0] io_off   = pri_widx - IO_BASE;

    // secondary and program decode
    // the secondary port only ever names whole words, so no size logic is needed
    // an address beyond a memory is ignored on write and answers zero on read
    wire        sec_dm   = (secondary_data_addr[23:DMEM_AW] == '0);
    wire        prog_pm  = (prog_addr[20:PMEM_AW] == '0);

    // data memory write lanes: lo is the addressed word, hi the odd word of a long
    // a byte write reads the old word in the same cycle and puts back the other
    // byte unchanged; two byte writes to one word in back-to-back cycles are safe
    // because each sees the word that the previous edge stored
    wire [DMEM_AW-1:0] idx_lo  = pri_widx[DMEM_AW-1:0];
    wire [DMEM_AW-1:0] idx_hi  = idx_lo | DMEM_AW'(1);
    wire [15:0]        old_lo  = dmem[idx_lo];
    wire [15:0]        byte_wd = (pri_lane == bus_fabric_pkg::LANE_LOW)
                                 ? {old_lo[15:8], core_wdata[7:0]}
                                 : {core_wdata[7:0], old_lo[7:0]};
    wire [15:0]        wd_lo   = is_byte ? byte_wd : core_wdata[15:0];
    wire               dm_we   = pri_wr && pri_dm && !pri_io;
    wire               we_hi   = dm_we && is_long;

    // data memory writes, byte merge, word and long
    // the write lands at the taking edge and the read path looks at memory one
    // cycle later, so a read taken at the same edge already returns the new data
    always_ff @(posedge mclk) begin
        if (dm_we) begin
            dmem[idx_lo] <= wd_lo;
        end
        if (we_hi) begin
            dmem[idx_hi] <= core_wdata[31:16];
        end
    end

    // program memory writes use the low half of the write data only
    // the upper half of the write data is ignored here; a program write that shares
    // the cycle with a data write stores the low half of that write's 32-bit data
    always_ff @(posedge mclk) begin
        if (prog_wr && prog_pm) begin
            pmem[prog_addr[PMEM_AW-1:0]] <= core_wdata[15:0];
        end
    end

    // stage 1: capture primary read request
    // captured every edge, read or not; only pri_rd_r decides whether the
    // next stage takes an answer, which keeps the enable logic small
    always_ff @(posedge mclk) begin
        if (rst) begin
            pri_rd_r   <= 1'b0;
            pri_io_r   <= 1'b0;
            pri_dm_r   <= 1'b0;
            pri_size_r <= bus_fabric_pkg::SZ_WORD;
            pri_lane_r <= 1'b0;
            pri_idx_r  <= '0;
        end else begin
            pri_rd_r   <= pri_rd;
            pri_io_r   <= pri_io;
            pri_dm_r   <= pri_dm;
            pri_size_r <= pri_size;
            pri_lane_r <= pri_lane;
            pri_idx_r  <= idx_lo;
        end
    end

    // stage 1: capture secondary and program read requests
    // the secondary request is captured at the same edge as the primary one, so
    // two reads taken together travel side by side through both stages
    always_ff @(posedge mclk) begin
        if (rst) begin
            sec_rd_r   <= 1'b0;
            sec_dm_r   <= 1'b0;
            sec_idx_r  <= '0;
            prog_rd_r  <= 1'b0;
            prog_pm_r  <= 1'b0;
            prog_idx_r <= '0;
        end else begin
            sec_rd_r   <= sec_rd;
            sec_dm_r   <= sec_dm;
            sec_idx_r  <= secondary_data_addr[DMEM_AW-1:0];
            prog_rd_r  <= prog_rd;
            prog_pm_r  <= prog_pm;
            prog_idx_r <= prog_addr[PMEM_AW-1:0];
        end
    end

    // stage 1: drive the peripheral bus for one cycle per access
    // address and write data follow the core every edge; only the strobes qualify
    // them. a peripheral must answer a read in the strobe cycle, which keeps its
    // latency equal to that of the data memory and adds no wait cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            periph_addr_r  <= '0;
            periph_wdata_r <= '0;
            periph_rd_r    <= 1'b0;
            periph_wr_r    <= 1'b0;
        end else begin
            periph_addr_r  <= io_off[15:0];
            periph_wdata_r <= core_wdata[15:0];
            periph_rd_r    <= pri_rd && pri_io;
            periph_wr_r    <= pri_wr && pri_io;
        end
    end

    // stage 2 read data: memory and peripheral share one latency
    // the memory is read in the cycle after the request, from the captured index,
    // so the answer is registered at the first edge after the one that took it
    // a byte answer is zero-extended, a word fills the low half, a long both
    wire [15:0] rd_lo   = dmem[pri_idx_r];
    wire [15:0] rd_hi   = dmem[pri_idx_r | DMEM_AW'(1)];
    wire [7:0]  rd_byte = (pri_lane_r == bus_fabric_pkg::LANE_LOW) ? rd_lo[7:0]
                                                                   : rd_lo[15:8];
    wire [31:0] dm_data = (pri_size_r == bus_fabric_pkg::SZ_BYTE) ? {24'h000000, rd_byte} :
                          (pri_size_r == bus_fabric_pkg::SZ_LONG) ? {rd_hi, rd_lo}
                                                                  : {16'h0000, rd_lo};

    // primary answer select: peripheral, data memory or zero
    // a peripheral answer fills the low half only; an address that is neither
    // memory nor window reads as zero rather than stale data
    always_comb begin
        core_rdata_nxt = 32'h00000000;
        if (pri_io_r) begin
            core_rdata_nxt = {16'h0000, periph_rdata};
        end else if (pri_dm_r) begin
            core_rdata_nxt = dm_data;
        end
    end

    // secondary and program answer select
    // out-of-range words read as zero on both ports
    always_comb begin
        sec_data_nxt   = sec_dm_r ? dmem[sec_idx_r] : 16'h0000;
        prog_rdata_nxt = prog_pm_r ? pmem[prog_idx_r] : 16'h0000;
    end

    // stage 2: register primary answer
    // the data register loads only on a read, so it holds between answers
    // while the valid flag drops after one cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            core_rdata_r  <= '0;
            core_rvalid_r <= 1'b0;
        end else begin
            core_rvalid_r <= pri_rd_r;
            if (pri_rd_r) begin
                core_rdata_r <= core_rdata_nxt;
            end
        end
    end

    // stage 2: register secondary answer in the same cycle as the primary
    // same depth as the primary path, so a dual read answers on one edge
    // and the core can use both words in the same instruction cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            sec_data_r   <= '0;
            sec_rvalid_r <= 1'b0;
        end else begin
            sec_rvalid_r <= sec_rd_r;
            if (sec_rd_r) begin
                sec_data_r <= sec_data_nxt;
            end
        end
    end

    // stage 2: register program answer
    // the program path has the same two-edge latency as the data paths
    // so fetches and data reads line up in the core's pipeline
    always_ff @(posedge mclk) begin
        if (rst) begin
            prog_rdata_r  <= '0;
            prog_rvalid_r <= 1'b0;
        end else begin
            prog_rvalid_r <= prog_rd_r;
            if (prog_rd_r) begin
                prog_rdata_r <= prog_rdata_nxt;
            end
        end
    end

    // outputs straight from flip-flops
    // every output below is a register, so no output glitches on a decode
    // change and downstream timing starts at a clock edge
    assign prog_rdata          = prog_rdata_r;
    assign prog_rvalid         = prog_rvalid_r;
    assign core_rdata          = core_rdata_r;
    assign core_rvalid         = core_rvalid_r;
    assign secondary_read_data = sec_data_r;
    assign sec_rvalid          = sec_rvalid_r;
    assign periph_addr         = periph_addr_r;
    assign periph_wdata        = periph_wdata_r;
    assign periph_rd           = periph_rd_r;
    assign periph_wr           = periph_wr_r;

endmodule : core_bus_fabric

// ### tb/periph_model.sv
// peripheral register model: sixteen word registers behind the peripheral bus
// assumes strobes from the fabric; reads are answered in the strobe cycle
module periph_model (
    input  wire logic        mclk,
    input  wire logic [15:0] periph_addr,
    input  wire logic [15:0] periph_wdata,
    input  wire logic        periph_rd,
    input  wire logic        periph_wr,
    output logic      [15:0] periph_rdata
);
    logic [15:0] regs [16];
    logic [15:0] last_r = 16'h0000;

    // store on the write strobe, remember the last answer
    always_ff @(posedge mclk) begin
        if (periph_wr) regs[periph_addr[3:0]] <= periph_wdata;
        if (periph_rd) last_r <= periph_rdata;
    end
    // answer at once; outside a read the bus shows the inverse of the last answer
    assign periph_rdata = periph_rd ? regs[periph_addr[3:0]] : ~last_r;
endmodule : periph_model

// ### tb/core_bus_fabric_checker.sv
// checker: latency and routing relations on the bus fabric's ports
// assumes one clock domain with synchronous active-high reset
module core_bus_fabric_checker #(
    parameter logic [23:0] IO_BASE  = bus_fabric_pkg::IO_BASE_DEF,
    parameter logic [23:0] IO_WORDS = bus_fabric_pkg::IO_WORDS_DEF
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        prog_rd,
    input wire logic        prog_rvalid,
    input wire logic [23:0] primary_data_addr,
    input wire logic        pri_rd,
    input wire logic        pri_wr,
    input wire logic [1:0]  pri_size,
    input wire logic [31:0] core_wdata,
    input wire logic [31:0] core_rdata,
    input wire logic        core_rvalid,
    input wire logic        sec_rd,
    input wire logic        sec_rvalid,
    input wire logic [15:0] periph_addr,
    input wire logic [15:0] periph_wdata,
    input wire logic        periph_rd,
    input wire logic        periph_wr,
    input wire logic [15:0] periph_rdata
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // window decode on the word address; a long uses its even word, bytes never reach it
    wire        is_byte = pri_size == bus_fabric_pkg::SZ_BYTE;
    wire        is_long = pri_size == bus_fabric_pkg::SZ_LONG;
    wire [23:0] io_word = is_long ? {primary_data_addr[23:1], 1'b0} : primary_data_addr;
    wire [23:0] io_off  = io_word - IO_BASE;
    wire        io_hit  = io_word >= IO_BASE && io_off < IO_WORDS && !is_byte;

    a_pri_read_lat: assert property (pri_rd |-> ##2 core_rvalid)
        else $error("primary read answer late");
    a_dual_read_pair: assert property (pri_rd && sec_rd |->
        ##2 core_rvalid && sec_rvalid)
        else $error("dual read answers apart");
    a_sec_word_only: assert property (sec_rd && !pri_rd && !pri_wr |->
        ##1 !periph_rd && !periph_wr)
        else $error("secondary read reached peripherals");
    a_prog_read_lat: assert property (prog_rd |-> ##2 prog_rvalid)
        else $error("program read answer late");
    a_io_read_strobe: assert property (pri_rd && io_hit |->
        ##1 periph_rd && periph_addr == $past(io_off[15:0]))
        else $error("peripheral read strobe wrong");
    a_io_write_data: assert property (pri_wr && io_hit |->
        ##1 periph_wr && periph_wdata == $past(core_wdata[15:0]))
        else $error("peripheral write data wrong");
    a_byte_not_io: assert property ((pri_rd || pri_wr) && is_byte |->
        ##1 !periph_rd && !periph_wr)
        else $error("byte access reached peripherals");
    a_io_no_wait: assert property (periph_rd |->
        ##1 core_rvalid && core_rdata == {16'h0000, $past(periph_rdata)})
        else $error("peripheral read delayed or lost");

    c_dual: cover property (pri_rd && sec_rd);
    c_io_read: cover property (pri_rd && io_hit);
    c_byte_write: cover property (pri_wr && is_byte);
    c_prog_read: cover property (prog_rd);
endmodule : core_bus_fabric_checker

bind core_bus_fabric core_bus_fabric_checker #(.IO_BASE(IO_BASE), .IO_WORDS(IO_WORDS)) chk_i (
    .mclk, .rst, .prog_rd, .prog_rvalid, .primary_data_addr, .pri_rd, .pri_wr, .pri_size,
    .core_wdata, .core_rdata, .core_rvalid, .sec_rd, .sec_rvalid, .periph_addr,
    .periph_wdata, .periph_rd, .periph_wr, .periph_rdata);

// ### tb/core_bus_fabric_tb_top.sv
// testbench: random and corner accesses on every port of the bus fabric
// assumes default parameters and the peripheral model on the peripheral bus
module core_bus_fabric_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] IOB = bus_fabric_pkg::IO_BASE_DEF;
    localparam logic [1:0]  SB  = bus_fabric_pkg::SZ_BYTE;
    localparam logic [1:0]  SW  = bus_fabric_pkg::SZ_WORD;
    localparam logic [1:0]  SL  = bus_fabric_pkg::SZ_LONG;
    logic        mclk, rst, prog_rd, prog_wr, pri_rd, pri_wr, sec_rd;
    logic        prog_rvalid, core_rvalid, sec_rvalid, periph_rd, periph_wr;
    logic [20:0] prog_addr;
    logic [23:0] primary_data_addr, secondary_data_addr;
    logic [1:0]  pri_size;
    logic [31:0] core_wdata, core_rdata, d;
    logic [15:0] prog_rdata, secondary_read_data, periph_addr, periph_wdata, periph_rdata;
    logic [15:0] dm [4096];
    logic [15:0] io [6];
    logic [11:0] w;
    int          failures = 0, n_tests = 0, seed = 41, cycles = 0;

    core_bus_fabric uut (.mclk, .rst, .prog_addr, .prog_rd, .prog_wr, .prog_rdata, .prog_rvalid,
        .primary_data_addr, .pri_rd, .pri_wr, .pri_size, .core_wdata, .core_rdata,
        .core_rvalid, .secondary_data_addr, .sec_rd, .secondary_read_data, .sec_rvalid,
        .periph_addr, .periph_wdata, .periph_rd, .periph_wr, .periph_rdata);
    periph_model partner (.mclk, .periph_addr, .periph_wdata, .periph_rd, .periph_wr,
        .periph_rdata);

    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task chk_flag(input logic got);
        chk({31'h0, got}, 32'h1);
    endtask : chk_flag
    // expected answers worked out from the bench's own copies and the pairing rules
    function automatic logic [31:0] exp_long(input logic [11:0] a);
        return {dm[a | 12'h001], dm[a]};
    endfunction : exp_long
    function automatic logic [31:0] exp_byte(input logic [15:0] wd, input logic lane);
        return {24'h000000, lane ? wd[15:8] : wd[7:0]};
    endfunction : exp_byte
    // one request cycle; flags are pri_rd, pri_wr, sec_rd, prog_rd, prog_wr
    task req(input logic [4:0] f, input logic [1:0] sz, input logic [23:0] a,
             input logic [31:0] wd);
        @(negedge mclk);
        {pri_rd, pri_wr, sec_rd, prog_rd, prog_wr} = f;
        pri_size = sz;
        primary_data_addr = a;
        secondary_data_addr = a | 24'h000001; // odd partner word of the primary
        prog_addr = a[20:0];
        core_wdata = wd;
        @(posedge mclk);
        @(negedge mclk);
        {pri_rd, pri_wr, sec_rd, prog_rd, prog_wr} = 5'h00;
        if (f[4] | f[2] | f[1]) @(negedge mclk); // answers stand in the second cycle
    endtask : req
    task wrap_up;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        {rst, pri_rd, pri_wr, sec_rd, prog_rd, prog_wr} = 6'h20;
        {prog_addr, primary_data_addr, secondary_data_addr} = 69'h0;
        pri_size = SW;
        core_wdata = 32'h0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        chk({27'h0, prog_rvalid, core_rvalid, sec_rvalid,
             periph_rd, periph_wr}, 32'h0);
        // program words with junk in the upper write half, top word of a 4096-word quarter first
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            w = (i == 0) ? 12'hFFF : d[27:16];
            req(5'h01, SW, {10'h0, d[31:30], w}, d);
            req(5'h02, SW, {10'h0, d[31:30], w}, 32'h0);
            chk({16'h0, prog_rdata}, {16'h0, d[15:0]});
            chk_flag(prog_rvalid);
        end
        // long writes, then primary long and secondary word read together
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            w = (i == 0) ? 12'hFFE : {d[11:1], 1'b0};
            d = $random(seed);
            dm[w] = d[15:0];
            dm[w | 12'h1] = d[31:16];
            req(5'h08, SL, {12'h0, w}, d);
            req(5'h14, SL, {12'h0, w}, 32'h0);
            chk(core_rdata, exp_long(w));
            chk_flag(core_rvalid);
            chk({16'h0, secondary_read_data}, {16'h0, dm[w | 12'h1]});
            chk_flag(sec_rvalid);
        end
        // byte lanes with the top address bit set merge into one low-half word
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            w = d[27:16];
            req(5'h08, SB, {11'h400, w, 1'b0}, d);
            req(5'h08, SB, {11'h400, w, 1'b1}, {24'h0, d[15:8]});
            req(5'h10, SW, {12'h0, w}, 32'h0);
            chk(core_rdata, {16'h0, d[15:0]});
            req(5'h10, SB, {11'h400, w, 1'b1}, 32'h0);
            chk(core_rdata, exp_byte(d[15:0], 1'b1));
            req(5'h10, SB, {11'h400, w, 1'b0}, 32'h0);
            chk(core_rdata, exp_byte(d[15:0], 1'b0));
        end
        // peripheral window with word, long and the code taken as word
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            io[i] = d[15:0];
            req(5'h08, 2'(i % 3 + 1), IOB + 24'(i), d);
            req(5'h10, 2'(i % 3 + 1), IOB + 24'(i), 32'h0);
            chk(core_rdata, {16'h0, io[i]});
        end
        // neither data memory nor window reads as zero
        req(5'h14, SW, 24'h010000, 32'h0);
        chk(core_rdata, 32'h0);
        chk({16'h0, secondary_read_data}, 32'h0);
        wrap_up();
    end
endmodule : core_bus_fabric_tb_top
